// *** logic/sdma_params.svh ***
// constants of the descriptor dma engine: offsets, field positions, resets
`ifndef SDMA_PARAMS_SVH
`define SDMA_PARAMS_SVH
`define REG_GLOBAL_MODE 8'h00
`define REG_GCMD 8'h04
`define REG_TX_BASE 8'h08
`define REG_TX_LAST 8'h0C
`define REG_RX_BASE 8'h10
`define REG_RX_LAST 8'h14
`define REG_TX_CUR 8'h18
`define REG_RX_CUR 8'h1C
`define REG_STATUS 8'h20
`define GM_LIST_END_BIT 0
`define CMD_INIT_TX 0
`define CMD_TX_POLL 1
`define CMD_TX_RESET 2
`define CMD_INIT_RX 3
`define CMD_RX_RESET 4
`define D_FRAME_END 31
`define D_HOLD 30
`define D_HOST_IRQ 29
`define D_CNT_HI 28
`define D_CNT_LO 16
`define D_C 30
`define D_RA 9
`define D_W3_OFS 32'h0000000C
`define D_W4_OFS 32'h00000010
`define BURST_LAST 2'h2
`define ADDR_RST 32'h00000000
`endif

// *** logic/sdma_pkg.sv ***
// types shared by the descriptor dma engine and its bench
package sdma_pkg;
  typedef enum logic [1:0] {BUS_IDLE, BUS_TX, BUS_RX} bus_st_t;
  typedef enum logic [2:0] {T_OFF, T_FETCH, T_LOAD, T_EMIT, T_WB} tx_ph_t;
  typedef enum logic [2:0] {R_OFF, R_FETCH, R_FILL, R_WB3, R_WB4} rx_ph_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } regbus_t;
  typedef struct packed {
    logic req;
    logic we;
    logic last;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } mem_rsp_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic frame_end;
  } byte_xfer_t;
  typedef struct packed {
    logic tx_done;
    logic tx_err;
    logic tx_irq;
    logic tx_halt;
    logic rx_done;
    logic rx_irq;
    logic rx_halt;
  } events_t;
  typedef struct packed {
    bus_st_t st;
    logic rr;
    logic [1:0] wc;
    logic mode;
    logic [31:0] rdata;
    events_t ev;
    tx_ph_t tx_ph;
    logic [31:0] tx_base;
    logic [31:0] tx_last;
    logic [31:0] tx_cur;
    logic [31:0] tx_next;
    logic [31:0] tx_ptr;
    logic [12:0] tx_cnt;
    logic tx_fend;
    logic tx_hold;
    logic tx_irq;
    logic tx_abort;
    logic tx_stop;
    logic tx_halt;
    logic [31:0] tx_word;
    rx_ph_t rx_ph;
    logic [31:0] rx_base;
    logic [31:0] rx_last;
    logic [31:0] rx_cur;
    logic [31:0] rx_next;
    logic [31:0] rx_dptr;
    logic [31:0] rx_first;
    logic [12:0] rx_size;
    logic [12:0] rx_bno;
    logic [2:0] rx_fill;
    logic [31:0] rx_word;
    logic rx_wfull;
    logic rx_wfe;
    logic rx_infrm;
    logic rx_hold;
    logic rx_irq;
    logic rx_abort;
    logic rx_stop;
    logic rx_halt;
  } dma_state_t;
endpackage

// *** logic/serial_descriptor_dma.sv ***
// descriptor driven dma engine: one transmit and one receive list channel
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "sdma_params.svh"

// Notes on behaviour
// - bytes move unswapped, little endian lanes
// - one list-end mode for all channels
// - transmit descriptor is four aligned words
// - first three words fetched in one burst
// - fourth word written back on completion
// - transmit list starts at transmit base
// - word0 frame end, hold, irq, count
// - last buffer byte carries frame-end mark
// - hold mode: branch or park until poll/init
// - last-address mode: park on match until rewrite
// - exactly byte count bytes read, max 8191
// - zero count without frame end flags error
// - host irq after all buffer bytes moved
// - descriptor read once and held on chip
// - init mid-buffer restarts at base, reset stops at base
// - transmit buffer may start at any byte
// - complete bit set on normal end or reset
// - receive descriptor five words, three fetched
// - fifth word points first desc to end desc
// - receive list starts at receive base
// - frame-end marks travel through the fifos
// - receive hold: interrupt then park channel
module serial_descriptor_dma (
  input wire logic sys_clk,
  input wire logic rst,
  input wire sdma_pkg::regbus_t reg_in,
  output logic [31:0] reg_rdata,
  output sdma_pkg::mem_req_t mem_out,
  input wire sdma_pkg::mem_rsp_t mem_in,
  output sdma_pkg::byte_xfer_t tx_fifo,
  input wire logic tx_fifo_ready,
  input wire sdma_pkg::byte_xfer_t rx_fifo,
  output logic rx_fifo_ready,
  output sdma_pkg::events_t events
);
  import sdma_pkg::*;

  dma_state_t s;
  dma_state_t next_s;

  // list end test shared by both directions
  function automatic logic list_end(input logic mode, input logic hold,
                                    input logic [31:0] cur, input logic [31:0] last);
    list_end = mode ? (cur == last) : hold;
  endfunction

  function automatic logic [31:0] word_addr(input logic [31:0] a);
    word_addr = {a[31:2], 2'h0};
  endfunction

  logic tx_need;
  logic rx_need;
  logic tx_fire;
  logic rx_fire;
  logic [12:0] rx_total;

  assign tx_need = (s.tx_ph == T_FETCH) || (s.tx_ph == T_LOAD) || (s.tx_ph == T_WB);
  assign rx_need = (s.rx_ph == R_FETCH) || (s.rx_ph == R_WB3) || (s.rx_ph == R_WB4)
                   || ((s.rx_ph == R_FILL) && s.rx_wfull);
  assign rx_total = s.rx_bno + {10'h000, s.rx_fill};

  // byte k of a word is lane k, no swap
  assign tx_fifo.valid = (s.tx_ph == T_EMIT) && !s.tx_abort;
  assign tx_fifo.data = s.tx_word[{s.tx_ptr[1:0], 3'h0} +: 8];
  assign tx_fifo.frame_end = s.tx_fend && (s.tx_cnt == 13'h0001);
  assign tx_fire = tx_fifo.valid && tx_fifo_ready;
  assign rx_fifo_ready = (s.rx_ph == R_FILL) && !s.rx_wfull && !s.rx_abort;
  assign rx_fire = rx_fifo_ready && rx_fifo.valid;
  assign reg_rdata = s.rdata;
  assign events = s.ev;

  // bus master port: one owner at a time
  always_comb begin
    mem_out.req = s.st != BUS_IDLE;
    mem_out.we = 1'b0;
    mem_out.last = 1'b1;
    mem_out.addr = `ADDR_RST;
    mem_out.wdata = 32'h00000000;
    if (s.st == BUS_TX) begin
      unique case (s.tx_ph)
        T_FETCH: begin
          mem_out.addr = s.tx_cur + {28'h0000000, s.wc, 2'h0};
          mem_out.last = s.wc == `BURST_LAST;
        end
        T_LOAD: mem_out.addr = word_addr(s.tx_ptr);
        T_WB: begin
          mem_out.we = 1'b1;
          mem_out.addr = s.tx_cur + `D_W3_OFS;
          mem_out.wdata[`D_C] = 1'b1;
        end
        default: mem_out.req = 1'b0;
      endcase
    end else if (s.st == BUS_RX) begin
      unique case (s.rx_ph)
        R_FETCH: begin
          mem_out.addr = s.rx_cur + {28'h0000000, s.wc, 2'h0};
          mem_out.last = s.wc == `BURST_LAST;
        end
        R_FILL: begin
          mem_out.we = 1'b1;
          mem_out.addr = s.rx_dptr + {19'h00000, s.rx_bno};
          mem_out.wdata = s.rx_word;
        end
        R_WB3: begin
          mem_out.we = 1'b1;
          mem_out.addr = s.rx_cur + `D_W3_OFS;
          mem_out.wdata[`D_FRAME_END] = s.rx_wfe;
          mem_out.wdata[`D_C] = 1'b1;
          mem_out.wdata[`D_CNT_HI:`D_CNT_LO] = s.rx_bno;
          mem_out.wdata[`D_RA] = s.rx_abort;
        end
        R_WB4: begin
          mem_out.we = 1'b1;
          mem_out.addr = s.rx_first + `D_W4_OFS;
          mem_out.wdata = s.rx_cur;
        end
        default: mem_out.req = 1'b0;
      endcase
    end
  end

  always_comb begin
    next_s = s;
    next_s.ev = '0;
    next_s.rdata = 32'h00000000;
    if (reg_in.rd) begin
      unique case (reg_in.addr)
        `REG_GLOBAL_MODE: next_s.rdata[`GM_LIST_END_BIT] = s.mode;
        `REG_TX_BASE: next_s.rdata = s.tx_base;
        `REG_TX_LAST: next_s.rdata = s.tx_last;
        `REG_RX_BASE: next_s.rdata = s.rx_base;
        `REG_RX_LAST: next_s.rdata = s.rx_last;
        `REG_TX_CUR: next_s.rdata = s.tx_cur;
        `REG_RX_CUR: next_s.rdata = s.rx_cur;
        `REG_STATUS: next_s.rdata[3:0] = {s.rx_halt, s.tx_halt,
                                          s.rx_ph != R_OFF, s.tx_ph != T_OFF};
        default: next_s.rdata = 32'h00000000;
      endcase
    end

    // bus arbitration, round robin between directions
    if (s.st == BUS_IDLE) begin
      next_s.wc = 2'h0;
      if (tx_need && (!rx_need || !s.rr)) begin
        next_s.st = BUS_TX;
        next_s.rr = 1'b1;
      end else if (rx_need) begin
        next_s.st = BUS_RX;
        next_s.rr = 1'b0;
      end
    end

    // transmit direction
    if ((s.st == BUS_TX) && mem_in.ack) begin
      next_s.st = BUS_IDLE;
      unique case (s.tx_ph)
        T_FETCH: begin
          next_s.wc = s.wc + 2'h1;
          if (s.wc != `BURST_LAST) next_s.st = BUS_TX;
          unique case (s.wc)
            2'h0: begin
              next_s.tx_fend = mem_in.rdata[`D_FRAME_END];
              next_s.tx_hold = mem_in.rdata[`D_HOLD];
              next_s.tx_irq = mem_in.rdata[`D_HOST_IRQ];
              next_s.tx_cnt = mem_in.rdata[`D_CNT_HI:`D_CNT_LO];
            end
            2'h1: next_s.tx_next = mem_in.rdata;
            default: begin
              next_s.tx_ptr = mem_in.rdata;
              if (s.tx_abort || (s.tx_cnt == 13'h0000)) next_s.tx_ph = T_WB;
              else next_s.tx_ph = T_LOAD;
              // nothing to send and no frame end
              next_s.ev.tx_err = (s.tx_cnt == 13'h0000) && !s.tx_fend;
            end
          endcase
        end
        T_LOAD: begin
          next_s.tx_word = mem_in.rdata;
          next_s.tx_ph = s.tx_abort ? T_WB : T_EMIT;
        end
        T_WB: begin
          next_s.ev.tx_done = 1'b1;
          next_s.tx_abort = 1'b0;
          next_s.tx_stop = 1'b0;
          if (s.tx_abort) begin
            next_s.tx_cur = s.tx_base;
            next_s.tx_ph = s.tx_stop ? T_OFF : T_FETCH;
          end else if (list_end(s.mode, s.tx_hold, s.tx_cur, s.tx_last)) begin
            next_s.tx_ph = T_OFF;
            next_s.tx_halt = 1'b1;
            next_s.ev.tx_halt = 1'b1;
          end else begin
            next_s.tx_cur = s.tx_next;
            next_s.tx_ph = T_FETCH;
          end
        end
        default: next_s.st = BUS_IDLE;
      endcase
    end
    if (s.tx_ph == T_EMIT) begin
      if (s.tx_abort) begin
        next_s.tx_ph = T_WB;
      end else if (tx_fire) begin
        next_s.tx_ptr = s.tx_ptr + 32'h00000001;
        next_s.tx_cnt = s.tx_cnt - 13'h0001;
        if (s.tx_cnt == 13'h0001) begin
          next_s.tx_ph = T_WB;
          next_s.ev.tx_irq = s.tx_irq;
        end else if (s.tx_ptr[1:0] == 2'h3) begin
          next_s.tx_ph = T_LOAD;
        end
      end
    end

    // receive direction
    if (rx_fire) begin
      next_s.rx_word[{s.rx_fill[1:0], 3'h0} +: 8] = rx_fifo.data;
      next_s.rx_fill = s.rx_fill + 3'h1;
      next_s.rx_infrm = !rx_fifo.frame_end;
      if (rx_fifo.frame_end) begin
        next_s.rx_wfe = 1'b1;
        next_s.rx_wfull = 1'b1;
      end else if ((s.rx_fill == 3'h3) || (rx_total + 13'h0001 == s.rx_size)) begin
        next_s.rx_wfull = 1'b1;
      end
    end
    if ((s.rx_ph == R_FILL) && s.rx_abort && !s.rx_wfull) begin
      if (s.rx_fill != 3'h0) next_s.rx_wfull = 1'b1;
      else next_s.rx_ph = R_WB3;
    end
    if ((s.st == BUS_RX) && mem_in.ack) begin
      next_s.st = BUS_IDLE;
      unique case (s.rx_ph)
        R_FETCH: begin
          next_s.wc = s.wc + 2'h1;
          if (s.wc != `BURST_LAST) next_s.st = BUS_RX;
          unique case (s.wc)
            2'h0: begin
              next_s.rx_hold = mem_in.rdata[`D_HOLD];
              next_s.rx_irq = mem_in.rdata[`D_HOST_IRQ];
              next_s.rx_size = mem_in.rdata[`D_CNT_HI:`D_CNT_LO];
            end
            2'h1: next_s.rx_next = mem_in.rdata;
            default: begin
              next_s.rx_dptr = mem_in.rdata;
              next_s.rx_bno = 13'h0000;
              next_s.rx_fill = 3'h0;
              next_s.rx_word = 32'h00000000;
              if (!s.rx_infrm) next_s.rx_first = s.rx_cur;
              next_s.rx_ph = (s.rx_size == 13'h0000) ? R_WB3 : R_FILL;
            end
          endcase
        end
        R_FILL: begin
          next_s.rx_bno = rx_total;
          next_s.rx_fill = 3'h0;
          next_s.rx_word = 32'h00000000;
          next_s.rx_wfull = 1'b0;
          if (s.rx_wfe || s.rx_abort || (rx_total == s.rx_size)) next_s.rx_ph = R_WB3;
        end
        R_WB3: begin
          next_s.ev.rx_irq = s.rx_irq;
          next_s.rx_ph = R_WB4;
        end
        default: next_s.st = BUS_IDLE;
      endcase
      // the end pointer is written only when a frame closed here
      if ((s.rx_ph == R_WB4) || ((s.rx_ph == R_WB3) && !s.rx_wfe)) begin
        next_s.ev.rx_done = 1'b1;
        next_s.rx_wfe = 1'b0;
        next_s.rx_abort = 1'b0;
        next_s.rx_stop = 1'b0;
        if (s.rx_abort) begin
          next_s.rx_infrm = 1'b0;
          next_s.rx_cur = s.rx_base;
          next_s.rx_ph = s.rx_stop ? R_OFF : R_FETCH;
        end else if (list_end(s.mode, s.rx_hold, s.rx_cur, s.rx_last)) begin
          next_s.rx_ph = R_OFF;
          next_s.rx_halt = 1'b1;
          next_s.ev.rx_halt = 1'b1;
        end else begin
          next_s.rx_cur = s.rx_next;
          next_s.rx_ph = R_FETCH;
        end
      end
    end

    // software writes; commands on a busy channel only arm an abort
    if (reg_in.wr) begin
      unique case (reg_in.addr)
        `REG_GLOBAL_MODE: next_s.mode = reg_in.wdata[`GM_LIST_END_BIT];
        `REG_TX_BASE: next_s.tx_base = reg_in.wdata;
        `REG_RX_BASE: next_s.rx_base = reg_in.wdata;
        `REG_TX_LAST: begin
          next_s.tx_last = reg_in.wdata;
          if ((s.tx_ph == T_OFF) && s.tx_halt && s.mode) begin
            next_s.tx_cur = s.tx_next;
            next_s.tx_ph = T_FETCH;
            next_s.tx_halt = 1'b0;
          end
        end
        `REG_RX_LAST: begin
          next_s.rx_last = reg_in.wdata;
          if ((s.rx_ph == R_OFF) && s.rx_halt && s.mode) begin
            next_s.rx_cur = s.rx_next;
            next_s.rx_ph = R_FETCH;
            next_s.rx_halt = 1'b0;
          end
        end
        `REG_GCMD: begin
          if (reg_in.wdata[`CMD_INIT_TX] || reg_in.wdata[`CMD_TX_RESET]) begin
            if (s.tx_ph == T_OFF) begin
              if (reg_in.wdata[`CMD_INIT_TX]) begin
                next_s.tx_cur = s.tx_base;
                next_s.tx_ph = T_FETCH;
                next_s.tx_halt = 1'b0;
              end
            end else begin
              next_s.tx_abort = 1'b1;
              next_s.tx_stop = reg_in.wdata[`CMD_TX_RESET];
            end
          end else if (reg_in.wdata[`CMD_TX_POLL] && (s.tx_ph == T_OFF) && s.tx_halt) begin
            next_s.tx_cur = s.tx_next;
            next_s.tx_ph = T_FETCH;
            next_s.tx_halt = 1'b0;
          end
          if (reg_in.wdata[`CMD_INIT_RX] || reg_in.wdata[`CMD_RX_RESET]) begin
            if (s.rx_ph == R_OFF) begin
              if (reg_in.wdata[`CMD_INIT_RX]) begin
                next_s.rx_cur = s.rx_base;
                next_s.rx_ph = R_FETCH;
                next_s.rx_halt = 1'b0;
                next_s.rx_infrm = 1'b0;
              end
            end else begin
              next_s.rx_abort = 1'b1;
              next_s.rx_stop = reg_in.wdata[`CMD_RX_RESET];
            end
          end
        end
        default: next_s.mode = s.mode;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// *** tb/sdma_sva.sv ***
// port checker for the descriptor dma engine
`timescale 1ns/100ps
`default_nettype none
`include "sdma_params.svh"
module sdma_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire sdma_pkg::regbus_t reg_in,
  input wire logic [31:0] reg_rdata,
  input wire sdma_pkg::mem_req_t mem_out,
  input wire sdma_pkg::mem_rsp_t mem_in,
  input wire sdma_pkg::byte_xfer_t tx_fifo,
  input wire logic tx_fifo_ready,
  input wire sdma_pkg::byte_xfer_t rx_fifo,
  input wire logic rx_fifo_ready,
  input wire sdma_pkg::events_t events
);
  import sdma_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_mode_wr;
    reg_in.wr && reg_in.addr == `REG_GLOBAL_MODE;
  endsequence
  sequence s_mode_rd;
    reg_in.rd && reg_in.addr == `REG_GLOBAL_MODE;
  endsequence
  sequence s_fetch_word;
    mem_out.req && !mem_out.we && !mem_out.last && mem_in.ack;
  endsequence
  chk_rdata_idle: assert property (!$past(reg_in.rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  chk_mode_read: assert property (s_mode_wr ##2 s_mode_rd |=>
    reg_rdata[`GM_LIST_END_BIT] == $past(reg_in.wdata[`GM_LIST_END_BIT], 3))
    else $error("list end mode readback wrong");
  chk_unmapped_zero: assert property (reg_in.rd && reg_in.addr > `REG_STATUS |=>
    reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_req_hold: assert property (mem_out.req && !mem_in.ack |=> mem_out.req &&
    $stable(mem_out.addr) && $stable(mem_out.we) && $stable(mem_out.wdata))
    else $error("bus request changed before ack");
  chk_fetch_step: assert property (s_fetch_word |=> mem_out.req && !mem_out.we &&
    mem_out.addr == $past(mem_out.addr) + 32'h4)
    else $error("descriptor burst did not step by one word");
  chk_wb_complete: assert property (mem_out.req && mem_out.we &&
    mem_out.addr[3:0] == 4'hC |-> mem_out.wdata[`D_C])
    else $error("write back without complete bit");
  // an abort may legally drop a byte that is still offered
  chk_tx_hold: assert property (tx_fifo.valid && !tx_fifo_ready && !reg_in.wr &&
    !$past(reg_in.wr) |=> tx_fifo.valid && $stable(tx_fifo.data) && $stable(tx_fifo.frame_end))
    else $error("offered byte changed while stalled");
  chk_halt_pulse: assert property ($rose(events.tx_halt) |=> !events.tx_halt)
    else $error("halt event longer than one cycle");
endmodule
bind serial_descriptor_dma sdma_chk i_chk (.sys_clk(sys_clk), .rst(rst), .reg_in(reg_in),
  .reg_rdata(reg_rdata), .mem_out(mem_out), .mem_in(mem_in), .tx_fifo(tx_fifo),
  .tx_fifo_ready(tx_fifo_ready), .rx_fifo(rx_fifo), .rx_fifo_ready(rx_fifo_ready),
  .events(events));
`default_nettype wire

// *** tb/sdma_mem.sv ***
// behavioural host memory answering the engine's bus master port
`timescale 1ns/100ps
`default_nettype none
module sdma_mem (
  input wire logic sys_clk,
  input wire logic rst,
  input wire sdma_pkg::mem_req_t mem_out,
  output var sdma_pkg::mem_rsp_t mem_in
);
  import sdma_pkg::*;
  logic [31:0] mem [0:4095];
  logic [1:0] wait_n;
  logic [1:0] lat;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_in <= '0;
      wait_n <= 2'h0;
      lat <= 2'h1;
    end else begin
      mem_in.ack <= 1'b0;
      // idle data bus keeps moving so a stale word never looks valid
      mem_in.rdata <= ~mem_in.rdata;
      if (mem_out.req && !mem_in.ack) begin
        if (wait_n >= lat) begin
          mem_in.ack <= 1'b1;
          wait_n <= 2'h0;
          // alternate prompt and slow answers
          lat <= (lat == 2'h1) ? 2'h3 : 2'h1;
          // word index only: descriptors sit on word boundaries, lanes unswapped
          if (mem_out.we) begin
            mem[mem_out.addr[13:2]] <= mem_out.wdata;
          end else begin
            mem_in.rdata <= mem[mem_out.addr[13:2]];
          end
        end else begin
          wait_n <= wait_n + 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the descriptor dma engine
`timescale 1ns/100ps
`default_nettype none
`include "sdma_params.svh"
module testbench;
  import sdma_pkg::*;
  logic sys_clk;
  logic rst;
  regbus_t reg_in;
  logic [31:0] reg_rdata;
  mem_req_t mem_out;
  mem_rsp_t mem_in;
  byte_xfer_t tx_fifo;
  logic tx_fifo_ready;
  byte_xfer_t rx_fifo;
  logic rx_fifo_ready;
  events_t events;
  logic stall;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  int ev_n [7];
  logic [8:0] txq [$];
  logic [7:0] exp_b [5] = '{8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
  serial_descriptor_dma i_dut (.sys_clk(sys_clk), .rst(rst), .reg_in(reg_in),
    .reg_rdata(reg_rdata), .mem_out(mem_out), .mem_in(mem_in), .tx_fifo(tx_fifo),
    .tx_fifo_ready(tx_fifo_ready), .rx_fifo(rx_fifo), .rx_fifo_ready(rx_fifo_ready),
    .events(events));
  sdma_mem i_mem (.sys_clk(sys_clk), .rst(rst), .mem_out(mem_out), .mem_in(mem_in));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // fifo takes a byte every other cycle unless stalled
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    tx_fifo_ready <= !stall && !tx_fifo_ready;
    if (tx_fifo.valid && tx_fifo_ready) begin
      txq.push_back({tx_fifo.frame_end, tx_fifo.data});
    end
    for (int k = 0; k < 7; k++) begin
      ev_n[k] = ev_n[k] + int'(events[k]);
    end
  end
  initial begin
    wait (cycles >= 20000);
    fails = fails + 1;
    conclude();
  end
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    reg_in <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk);
    reg_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    reg_in <= '0;
    #1 chk(reg_rdata & m, e);
  endtask
  task automatic wait_ev(input int k, input int n);
    for (int i = 0; i < 4000 && ev_n[k] < n; i++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic clear();
    ev_n = '{default: 0};
    txq.delete();
  endtask
  task automatic chk_tx(input int n);
    chk(32'(txq.size()), 32'(n));
    foreach (txq[i]) chk(32'(txq[i]), {23'h0, i % 5 == 4, exp_b[i % 5]});
  endtask
  task automatic desc(input logic [11:0] w, input logic [31:0] w0, input logic [31:0] nx,
    input logic [31:0] dp);
    i_mem.mem[w] = w0;
    i_mem.mem[w + 12'h1] = nx;
    i_mem.mem[w + 12'h2] = dp;
    i_mem.mem[w + 12'h3] = 32'h0;
  endtask
  // released rx lines show the inverse of the last byte
  task automatic rx_send(input logic [7:0] d, input logic fe);
    @(posedge sys_clk);
    rx_fifo <= '{valid: 1'b1, data: d, frame_end: fe};
    for (int i = 0; i < 200; i++) begin
      @(posedge sys_clk);
      if (rx_fifo_ready === 1'b1) break;
    end
    rx_fifo <= '{valid: 1'b0, data: ~d, frame_end: ~fe};
  endtask
  initial begin
    rst = 1'b1;
    reg_in = '0;
    rx_fifo = '0;
    stall = 1'b0;
    tx_fifo_ready = 1'b0;
    ev_n = '{default: 0};
    // descriptor words: frame end, hold, host irq, count; next; data
    desc(12'h040, 32'hA0050000, 32'h200, 32'h1001);
    desc(12'h080, 32'hC0000000, 32'h100, 32'h0);
    desc(12'h0C0, 32'h40000000, 32'h200, 32'h0);
    desc(12'h100, 32'h40080000, 32'h400, 32'h500);
    i_mem.mem[12'h104] = 32'h0;
    i_mem.mem[12'h400] = 32'h44332211;
    i_mem.mem[12'h401] = 32'h88776655;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`REG_TX_CUR, 32'hFFFFFFFF, `ADDR_RST);
    rd(`REG_STATUS, 32'hF, 32'h0);
    wr(8'h30, 32'hFFFFFFFF);
    rd(8'h30, 32'hFFFFFFFF, 32'h0);
    wr(`REG_GLOBAL_MODE, 32'h1);
    rd(`REG_GLOBAL_MODE, 32'h1, 32'h1);
    wr(`REG_GLOBAL_MODE, 32'h0);
    $display("test registers done");
    wr(`REG_TX_BASE, 32'h100);
    wr(`REG_GCMD, 32'h1);
    wait_ev(3, 1);
    chk_tx(5);
    chk(32'(ev_n[6]), 32'h2);
    chk(32'(ev_n[4]), 32'h1);
    chk(i_mem.mem[12'h043] & 32'h40000000, 32'h40000000);
    chk(i_mem.mem[12'h083] & 32'h40000000, 32'h40000000);
    rd(`REG_TX_CUR, 32'hFFFFFFFF, 32'h200);
    rd(`REG_STATUS, 32'h4, 32'h4);
    wr(`REG_GCMD, 32'h2);
    wait_ev(3, 2);
    chk_tx(10);
    $display("test hold mode done");
    clear();
    wr(`REG_TX_LAST, 32'h100);
    wr(`REG_GLOBAL_MODE, 32'h1);
    wr(`REG_TX_BASE, 32'h100);
    wr(`REG_GCMD, 32'h1);
    wait_ev(3, 1);
    chk_tx(5);
    rd(`REG_TX_CUR, 32'hFFFFFFFF, 32'h100);
    wr(`REG_TX_LAST, 32'h200);
    wait_ev(3, 2);
    chk(32'(ev_n[6]), 32'h2);
    rd(`REG_TX_CUR, 32'hFFFFFFFF, 32'h200);
    wr(`REG_GLOBAL_MODE, 32'h0);
    $display("test last address mode done");
    clear();
    wr(`REG_TX_BASE, 32'h300);
    wr(`REG_GCMD, 32'h1);
    wait_ev(3, 1);
    chk(32'(ev_n[5]), 32'h1);
    chk(32'(txq.size()), 32'h0);
    $display("test empty descriptor done");
    clear();
    i_mem.mem[12'h043] = 32'h0;
    stall <= 1'b1;
    wr(`REG_TX_BASE, 32'h100);
    wr(`REG_GCMD, 32'h1);
    repeat (40) @(posedge sys_clk);
    wr(`REG_TX_BASE, 32'h300);
    wr(`REG_GCMD, 32'h1);
    stall <= 1'b0;
    wait_ev(3, 1);
    chk(i_mem.mem[12'h043] & 32'h40000000, 32'h40000000);
    chk(32'(ev_n[5]), 32'h1);
    rd(`REG_TX_CUR, 32'hFFFFFFFF, 32'h300);
    clear();
    i_mem.mem[12'h043] = 32'h0;
    stall <= 1'b1;
    wr(`REG_TX_BASE, 32'h100);
    wr(`REG_GCMD, 32'h1);
    repeat (40) @(posedge sys_clk);
    wr(`REG_GCMD, 32'h4);
    repeat (40) @(posedge sys_clk);
    stall <= 1'b0;
    chk(i_mem.mem[12'h043] & 32'h40000000, 32'h40000000);
    rd(`REG_STATUS, 32'h1, 32'h0);
    $display("test abort done");
    clear();
    wr(`REG_RX_BASE, 32'h400);
    wr(`REG_GCMD, 32'h8);
    for (int k = 0; k < 4; k++) rx_send(8'(8'h11 * (k + 1)), k == 3);
    wait_ev(0, 1);
    chk(i_mem.mem[12'h140], 32'h44332211);
    chk(i_mem.mem[12'h103] & 32'hFFFF0000, 32'hC0040000);
    chk(i_mem.mem[12'h104], 32'h400);
    chk(32'(ev_n[2]), 32'h1);
    $display("test receive done");
    conclude();
  end
endmodule
`default_nettype wire
